// ### rtl/scd_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module scd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Streams
  scd_stream_if.dst wr,
  scd_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } scd_fifo_s;

  scd_fifo_s q;
  scd_fifo_s d;
  logic push;
  logic pop;

  assign wr.ready = (q.cnt != FULL_CNT);
  assign rd.valid = (q.cnt != '0);
  assign rd.data = q.mem[q.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = wr.data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // scd_fifo
`default_nettype wire

// ### rtl/scd_pkg.sv
// Constants, encodings and types shared by the serial command decoder
package scd_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 24;
  localparam int IDX_W = 5;
  localparam int BYTE_W = 8;
  localparam int PAGE_W = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int WRITE_BYTES = 3;
  localparam int SYNC_FILL_MIN = 3;
  localparam int ONES_W = 5;
  localparam logic [ONES_W-1:0] ONES_REALIGN = ONES_W'(SYNC_FILL_MIN * BYTE_W + BYTE_W - 1);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 10000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = $clog2(RESET_MIN_CYC + 1);
  localparam int INIT_CNT_W = 4;
  localparam logic [INIT_CNT_W-1:0] INIT_DELAY_CYC = 4'h8;

  // ----------------------------------------------------------------
  // Register indices, page 0
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] REG_CONFIGURATION = 5'h00;
  localparam logic [IDX_W-1:0] REG_CURRENT_DC_OFFSET = 5'h01;
  localparam logic [IDX_W-1:0] REG_CURRENT_GAIN = 5'h02;
  localparam logic [IDX_W-1:0] REG_VOLTAGE_DC_OFFSET = 5'h03;
  localparam logic [IDX_W-1:0] REG_VOLTAGE_GAIN = 5'h04;
  localparam logic [IDX_W-1:0] REG_CONVERSIONS_PER_CYCLE = 5'h05;
  localparam logic [IDX_W-1:0] REG_ENERGY_PULSE_RATE = 5'h06;
  localparam logic [IDX_W-1:0] REG_INSTANT_CURRENT = 5'h07;
  localparam logic [IDX_W-1:0] REG_INSTANT_VOLTAGE = 5'h08;
  localparam logic [IDX_W-1:0] REG_INSTANT_POWER = 5'h09;
  localparam logic [IDX_W-1:0] REG_ACTIVE_POWER = 5'h0a;
  localparam logic [IDX_W-1:0] REG_RMS_CURRENT = 5'h0b;
  localparam logic [IDX_W-1:0] REG_RMS_VOLTAGE = 5'h0c;
  localparam logic [IDX_W-1:0] REG_LINE_FREQUENCY_RATIO = 5'h0d;
  localparam logic [IDX_W-1:0] REG_POWER_OFFSET = 5'h0e;
  localparam logic [IDX_W-1:0] REG_EVENT_FLAGS = 5'h0f;
  localparam logic [IDX_W-1:0] REG_CURRENT_AC_OFFSET = 5'h10;
  localparam logic [IDX_W-1:0] REG_VOLTAGE_AC_OFFSET = 5'h11;
  localparam logic [IDX_W-1:0] REG_OPERATION_MODE = 5'h12;
  localparam logic [IDX_W-1:0] REG_TEMPERATURE = 5'h13;
  localparam logic [IDX_W-1:0] REG_AVG_REACTIVE_POWER = 5'h14;
  localparam logic [IDX_W-1:0] REG_INSTANT_REACTIVE_POWER = 5'h15;
  localparam logic [IDX_W-1:0] REG_PEAK_CURRENT = 5'h16;
  localparam logic [IDX_W-1:0] REG_PEAK_VOLTAGE = 5'h17;
  localparam logic [IDX_W-1:0] REG_TRIANGLE_REACTIVE_POWER = 5'h18;
  localparam logic [IDX_W-1:0] REG_POWER_FACTOR = 5'h19;
  localparam logic [IDX_W-1:0] REG_INTERRUPT_ENABLE_MASK = 5'h1a;
  localparam logic [IDX_W-1:0] REG_APPARENT_POWER = 5'h1b;
  localparam logic [IDX_W-1:0] REG_CONTROL = 5'h1c;
  localparam logic [IDX_W-1:0] REG_HARMONIC_ACTIVE_POWER = 5'h1d;
  localparam logic [IDX_W-1:0] REG_FUNDAMENTAL_ACTIVE_POWER = 5'h1e;
  localparam logic [IDX_W-1:0] REG_FUNDAMENTAL_REACTIVE_OR_PAGE = 5'h1f;
  localparam logic [PAGE_W-1:0] PAGE_DEFAULT = 6'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_ZERO = 24'h000000;
  localparam logic [DATA_W-1:0] CONFIGURATION_RESET = 24'h000001;
  localparam logic [DATA_W-1:0] GAIN_RESET = 24'h400000;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] CMD_SYNC_FILLER = 8'hff;
  localparam logic [BYTE_W-1:0] CMD_SYNC_TERMINATOR = 8'hfe;
  localparam logic [BYTE_W-1:0] CMD_POWER_UP_HALT = 8'ha0;
  localparam logic [BYTE_W-1:0] CMD_START_MASK = 8'hf7;
  localparam logic [BYTE_W-1:0] CMD_START_VAL = 8'he0;
  localparam logic [BYTE_W-1:0] CMD_PWR_DOWN_MASK = 8'he7;
  localparam logic [BYTE_W-1:0] CMD_PWR_DOWN_VAL = 8'h80;
  localparam logic [BYTE_W-1:0] CMD_REG_MASK = 8'h81;
  localparam logic [BYTE_W-1:0] CMD_REG_VAL = 8'h00;
  localparam int CONT_BIT = 3;
  localparam int PD_LSB = 3;
  localparam int DIR_BIT = 6;
  localparam int IDX_LSB = 1;
  localparam logic [1:0] PD_SOFT_RESET = 2'h0;
  localparam logic [1:0] PD_STANDBY = 2'h1;
  localparam logic [1:0] PD_SLEEP = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SCD_ACTIVE, SCD_STANDBY, SCD_SLEEP} scd_pwr_e;
  typedef enum logic {SCD_CMD, SCD_WDATA} scd_dec_e;

  // Registers whose content comes from the measurement engine
  function automatic logic scd_is_meas(input logic [IDX_W-1:0] idx);
    case (idx)
      REG_INSTANT_CURRENT, REG_INSTANT_VOLTAGE, REG_INSTANT_POWER, REG_ACTIVE_POWER,
      REG_RMS_CURRENT, REG_RMS_VOLTAGE, REG_TEMPERATURE, REG_AVG_REACTIVE_POWER,
      REG_INSTANT_REACTIVE_POWER, REG_PEAK_CURRENT, REG_PEAK_VOLTAGE,
      REG_TRIANGLE_REACTIVE_POWER, REG_POWER_FACTOR, REG_APPARENT_POWER,
      REG_HARMONIC_ACTIVE_POWER, REG_FUNDAMENTAL_ACTIVE_POWER,
      REG_FUNDAMENTAL_REACTIVE_OR_PAGE: scd_is_meas = 1'b1;
      default: scd_is_meas = 1'b0;
    endcase
  endfunction

endpackage

// ### rtl/scd_serial_command_decoder.sv
// Serial host port, command decoder and page-0 register file
`timescale 1ns/100ps
`default_nettype none
module scd_serial_command_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic reset_pin_n,
  // Measurement engine
  output logic [scd_pkg::IDX_W-1:0] meas_index,
  input wire logic [scd_pkg::DATA_W-1:0] meas_data,
  input wire logic [scd_pkg::DATA_W-1:0] status_set,
  // Command results
  output logic start_pulse,
  output logic continuous_select,
  output logic halt_pulse,
  output logic power_on_reset_pulse,
  output logic soft_reset_pulse,
  output logic abort_pulse,
  output logic invalid_cmd_pulse,
  output logic clocks_run,
  output logic analog_on,
  output logic rx_overflow,
  // Register contents
  output logic [scd_pkg::DATA_W-1:0] configuration,
  output logic [scd_pkg::DATA_W-1:0] operation_mode,
  output logic [scd_pkg::DATA_W-1:0] control,
  output logic [scd_pkg::DATA_W-1:0] interrupt_enable_mask,
  output logic [scd_pkg::DATA_W-1:0] event_flags,
  output logic [scd_pkg::PAGE_W-1:0] page
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cs_s;
    logic [2:0] sck_s;
    logic [1:0] sdi_s;
    logic [1:0] rstp_s;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [2:0] bit_cnt;
    logic [BYTE_W-1:0] rx_sh;
    logic [ONES_W-1:0] ones_cnt;
    logic push_v;
    logic [BYTE_W-1:0] push_data;
    logic ovf;
    logic [DATA_W-1:0] tx_sh;
    scd_dec_e dec;
    logic [IDX_W-1:0] w_idx;
    logic [1:0] w_cnt;
    logic [DATA_W-1:0] w_data;
    scd_pwr_e pwr;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic [31:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0] status;
    logic [PAGE_W-1:0] page;
    logic start_p;
    logic cont;
    logic halt_p;
    logic por_p;
    logic srst_p;
    logic abort_p;
    logic inval_p;
  } scd_core_s;

  localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(RESET_MIN_CYC - 1);
  localparam logic [RST_CNT_W-1:0] RST_DONE = RST_CNT_W'(RESET_MIN_CYC);
  localparam logic [1:0] W_LAST = 2'(WRITE_BYTES - 1);

  scd_core_s q;
  scd_core_s d;

  scd_stream_if #(.WIDTH(BYTE_W)) rx_in ();
  scd_stream_if #(.WIDTH(BYTE_W)) rx_out ();

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  scd_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr(rx_in),
    .rd(rx_out)
  );

  assign rx_in.valid = q.push_v;
  assign rx_in.data = q.push_data;
  // Decoder stalls while the device re-initialises after a reset
  assign rx_out.ready = (q.init_cnt == '0);

  logic sclk_rise;
  logic pin_reset;
  logic pop;
  logic do_reset;
  logic [BYTE_W-1:0] cmd;
  logic [IDX_W-1:0] cmd_idx;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] flag_clr;

  assign sclk_rise = q.sck_s[1] && !q.sck_s[2];
  assign pop = rx_out.valid && rx_out.ready;
  assign cmd = rx_out.data;
  assign cmd_idx = cmd[IDX_LSB +: IDX_W];
  assign wr_word = {q.w_data[DATA_W-BYTE_W-1:0], cmd};
  assign pin_reset = !q.rstp_s[1] && (q.rst_cnt == RST_LAST);

  // ----------------------------------------------------------------
  // Read value for the addressed register
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = REG_ZERO;
    if (q.page != PAGE_DEFAULT) begin
      if (cmd_idx == REG_FUNDAMENTAL_REACTIVE_OR_PAGE) begin
        rd_val = {{(DATA_W-PAGE_W){1'b0}}, q.page};
      end
    end else if (cmd_idx == REG_EVENT_FLAGS) begin
      rd_val = q.status;
    end else if (scd_is_meas(cmd_idx)) begin
      rd_val = meas_data;
    end else begin
      rd_val = q.regs[cmd_idx];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    do_reset = 1'b0;
    flag_clr = REG_ZERO;
    d.start_p = 1'b0;
    d.halt_p = 1'b0;
    d.por_p = 1'b0;
    d.srst_p = 1'b0;
    d.abort_p = 1'b0;
    d.inval_p = 1'b0;
    d.push_v = 1'b0;
    d.cs_s = {q.cs_s[0], cs_n};
    d.sck_s = {q.sck_s[1:0], sclk};
    d.sdi_s = {q.sdi_s[0], serial_in};
    d.rstp_s = {q.rstp_s[0], reset_pin_n};
    if (q.rstp_s[1]) begin
      d.rst_cnt = '0;
    end else if (q.rst_cnt != RST_DONE) begin
      d.rst_cnt = q.rst_cnt + 1'b1;
    end
    if (q.init_cnt != '0) begin
      d.init_cnt = q.init_cnt - 1'b1;
    end

    if (q.cs_s[1] || pin_reset) begin
      d.bit_cnt = '0;
      d.rx_sh = '0;
      d.ones_cnt = '0;
      d.tx_sh = REG_ZERO;
      d.dec = SCD_CMD;
      d.w_cnt = '0;
    end else if (sclk_rise) begin
      d.rx_sh = {q.rx_sh[BYTE_W-2:0], q.sdi_s[1]};
      d.tx_sh = {q.tx_sh[DATA_W-2:0], 1'b0};
      d.bit_cnt = q.bit_cnt + 1'b1;
      if (q.bit_cnt == 3'h7) begin
        d.push_v = 1'b1;
        d.push_data = d.rx_sh;
      end
      if (q.sdi_s[1]) begin
        if (q.ones_cnt != ONES_REALIGN) begin
          d.ones_cnt = q.ones_cnt + 1'b1;
        end
      end else begin
        d.ones_cnt = '0;
        if (q.ones_cnt == ONES_REALIGN) begin
          d.bit_cnt = '0;
          d.push_v = 1'b0;
          d.dec = SCD_CMD;
          d.w_cnt = '0;
        end
      end
    end
    if (q.push_v && !rx_in.ready) begin
      d.ovf = 1'b1;
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    if (pop) begin
      case (q.dec)
        SCD_CMD: begin
          if ((cmd & CMD_REG_MASK) == CMD_REG_VAL) begin
            if (cmd[DIR_BIT]) begin
              d.dec = SCD_WDATA;
              d.w_idx = cmd_idx;
              d.w_cnt = '0;
            end else begin
              d.tx_sh = rd_val;
            end
          end else if (cmd == CMD_SYNC_FILLER || cmd == CMD_SYNC_TERMINATOR) begin
            d.dec = SCD_CMD;
          end else begin
            d.abort_p = 1'b1;
            if ((cmd & CMD_START_MASK) == CMD_START_VAL) begin
              d.start_p = 1'b1;
              d.cont = cmd[CONT_BIT];
            end else if (cmd == CMD_POWER_UP_HALT) begin
              if (q.pwr != SCD_ACTIVE) begin
                d.por_p = 1'b1;
                do_reset = 1'b1;
              end else begin
                d.halt_p = 1'b1;
              end
            end else if ((cmd & CMD_PWR_DOWN_MASK) == CMD_PWR_DOWN_VAL) begin
              case (cmd[PD_LSB +: 2])
                PD_SOFT_RESET: begin
                  d.srst_p = 1'b1;
                  d.halt_p = 1'b1;
                  do_reset = 1'b1;
                end
                PD_STANDBY: begin
                  d.halt_p = 1'b1;
                  d.pwr = SCD_STANDBY;
                end
                PD_SLEEP: begin
                  d.halt_p = 1'b1;
                  d.pwr = SCD_SLEEP;
                end
                default: begin
                  d.inval_p = 1'b1;
                end
              endcase
            end else begin
              d.inval_p = 1'b1;
            end
          end
        end
        SCD_WDATA: begin
          d.w_data = wr_word;
          d.w_cnt = q.w_cnt + 1'b1;
          if (q.w_cnt == W_LAST) begin
            d.dec = SCD_CMD;
            if (q.w_idx == REG_FUNDAMENTAL_REACTIVE_OR_PAGE) begin
              d.page = wr_word[PAGE_W-1:0];
            end else if (q.page == PAGE_DEFAULT) begin
              if (q.w_idx == REG_EVENT_FLAGS) begin
                flag_clr = wr_word;
              end else if (!scd_is_meas(q.w_idx)) begin
                d.regs[q.w_idx] = wr_word;
              end
            end
          end
        end
        default: begin
          d.dec = SCD_CMD;
        end
      endcase
    end

    // Hardware sets win over a write-one clear in the same cycle
    d.status = (q.status & ~flag_clr) | status_set;

    if (do_reset || pin_reset) begin
      for (int i = 0; i < 32; i++) begin
        d.regs[i] = REG_ZERO;
      end
      d.regs[REG_CONFIGURATION] = CONFIGURATION_RESET;
      d.regs[REG_CURRENT_GAIN] = GAIN_RESET;
      d.regs[REG_VOLTAGE_GAIN] = GAIN_RESET;
      d.status = REG_ZERO;
      d.page = PAGE_DEFAULT;
      d.cont = 1'b0;
      d.ovf = 1'b0;
      d.pwr = SCD_ACTIVE;
      d.init_cnt = INIT_DELAY_CYC;
      d.dec = SCD_CMD;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.cs_s <= 2'h3;
      q.rstp_s <= 2'h3;
      q.regs[REG_CONFIGURATION] <= CONFIGURATION_RESET;
      q.regs[REG_CURRENT_GAIN] <= GAIN_RESET;
      q.regs[REG_VOLTAGE_GAIN] <= GAIN_RESET;
      q.dec <= SCD_CMD;
      q.pwr <= SCD_ACTIVE;
      q.init_cnt <= INIT_DELAY_CYC;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_out = q.tx_sh[DATA_W-1];
  assign meas_index = cmd_idx;
  assign start_pulse = q.start_p;
  assign continuous_select = q.cont;
  assign halt_pulse = q.halt_p;
  assign power_on_reset_pulse = q.por_p;
  assign soft_reset_pulse = q.srst_p;
  assign abort_pulse = q.abort_p;
  assign invalid_cmd_pulse = q.inval_p;
  assign clocks_run = (q.pwr != SCD_SLEEP);
  assign analog_on = (q.pwr == SCD_ACTIVE);
  assign rx_overflow = q.ovf;
  assign configuration = q.regs[REG_CONFIGURATION];
  assign operation_mode = q.regs[REG_OPERATION_MODE];
  assign control = q.regs[REG_CONTROL];
  assign interrupt_enable_mask = q.regs[REG_INTERRUPT_ENABLE_MASK];
  assign event_flags = q.status;
  assign page = q.page;
endmodule // scd_serial_command_decoder
`default_nettype wire

// ### rtl/scd_stream_if.sv
// Valid/ready byte stream between the serial front end, the FIFO and the decoder
`timescale 1ns/100ps
`default_nettype none
interface scd_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### verif/scd_checker.sv
// Pin-level assertions for the serial command decoder
`timescale 1ns/100ps
`default_nettype none
module scd_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Watched pins
  input wire logic cs_n,
  input wire logic serial_out,
  input wire logic start_pulse,
  input wire logic abort_pulse,
  input wire logic invalid_cmd_pulse,
  input wire logic soft_reset_pulse,
  input wire logic power_on_reset_pulse,
  input wire logic clocks_run,
  input wire logic analog_on,
  input wire logic [scd_pkg::DATA_W-1:0] configuration,
  input wire logic [scd_pkg::PAGE_W-1:0] page
);
  import scd_pkg::*;
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_start_aborts: assert property (start_pulse |-> abort_pulse)
    else $error("start without abort");
  a_start_single: assert property (start_pulse |=> !start_pulse)
    else $error("start pulse too long");
  a_invalid_aborts: assert property (invalid_cmd_pulse |-> abort_pulse && !start_pulse)
    else $error("invalid byte not aborting");
  a_sleep_all_off: assert property (!clocks_run |-> !analog_on)
    else $error("analog on while asleep");
  a_page_default: assert property ($rose(rstn) |-> page == PAGE_DEFAULT)
    else $error("page not zero after reset");
  a_soft_defaults: assert property (soft_reset_pulse |-> ##[1:3]
    (configuration == CONFIGURATION_RESET && page == PAGE_DEFAULT))
    else $error("soft reset left state");
  a_wake_active: assert property (power_on_reset_pulse |-> ##[1:3] analog_on)
    else $error("power-on reset not active");
  a_deselect_quiet: assert property (cs_n [*6] |-> !serial_out)
    else $error("output busy while deselected");
  c_start: cover property (start_pulse);
  c_soft: cover property (soft_reset_pulse);
  c_sleep: cover property (!clocks_run);
endmodule // scd_checker
bind scd_serial_command_decoder scd_checker i_chk (.core_clk, .rstn, .cs_n, .serial_out,
  .start_pulse, .abort_pulse, .invalid_cmd_pulse, .soft_reset_pulse, .power_on_reset_pulse,
  .clocks_run, .analog_on, .configuration, .page);
`default_nettype wire

// ### verif/scd_host_model.sv
// Host model clocking bytes through the serial port
`timescale 1ns/100ps
`default_nettype none
module scd_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    serial_in = 1'h0;
  end
  task automatic half();
    repeat (4) @(posedge core_clk);
    #3;
  endtask
  task automatic sel(input logic on);
    half();
    cs_n = !on;
    if (!on) serial_in = !serial_in;
    half();
  endtask
  // One shift clock, output bit taken at the rising edge
  task automatic bit_io(input logic b, output logic r);
    serial_in = b;
    half();
    sclk = 1'h1;
    r = serial_out;
    half();
    sclk = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask
endmodule // scd_host_model
`default_nettype wire

// ### verif/scd_serial_command_decoder_test.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/100ps
`default_nettype none
module scd_serial_command_decoder_test;
  import scd_pkg::*;
  logic core_clk, rstn, reset_pin_n, cs_n, sclk, serial_in, serial_out;
  logic start_pulse, continuous_select, halt_pulse, power_on_reset_pulse, soft_reset_pulse;
  logic abort_pulse, invalid_cmd_pulse, clocks_run, analog_on, rx_overflow;
  logic [IDX_W-1:0] meas_index;
  logic [DATA_W-1:0] meas_data, status_set, configuration, operation_mode, control, rd_q;
  logic [DATA_W-1:0] interrupt_enable_mask, event_flags;
  logic [PAGE_W-1:0] page;
  int num_errors = 0;
  int comparisons = 0;
  int invalid_seen = 0;
  int halt_seen = 0;
  scd_serial_command_decoder i_dut (.core_clk, .rstn, .cs_n, .sclk, .serial_in, .serial_out,
    .reset_pin_n, .meas_index, .meas_data, .status_set, .start_pulse, .continuous_select,
    .halt_pulse, .power_on_reset_pulse, .soft_reset_pulse, .abort_pulse, .invalid_cmd_pulse,
    .clocks_run, .analog_on, .rx_overflow, .configuration, .operation_mode, .control,
    .interrupt_enable_mask, .event_flags, .page);
  scd_host_model i_host (.core_clk, .cs_n, .sclk, .serial_in, .serial_out);
  // Measurement engine answers with a value that encodes the index asked for
  assign meas_data = {19'h2c3a5, meas_index};
  // ----
  // Helpers
  // ----
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] op, input logic [DATA_W-1:0] d, input int n = 3);
    logic [7:0] x;
    i_host.sel(1'h1);
    i_host.xfer(op, x);
    for (int b = 2; b > 2 - n; b--) i_host.xfer(d[b*8 +: 8], x);
    i_host.sel(1'h0);
  endtask
  task automatic rd(input logic [7:0] op, fill, output logic [DATA_W-1:0] d);
    logic [7:0] x;
    i_host.sel(1'h1);
    i_host.xfer(op, x);
    i_host.xfer(fill, d[23:16]);
    i_host.xfer(8'hff, d[15:8]);
    i_host.xfer(8'hff, d[7:0]);
    i_host.sel(1'h0);
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] x;
    i_host.sel(1'h1);
    i_host.xfer(op, x);
    i_host.sel(1'h0);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_cmds();
    logic [7:0] op [6] = '{8'he0, 8'h88, 8'ha0, 8'h90, 8'ha0, 8'he8};
    logic [2:0] st [6] = '{3'h3, 3'h1, 3'h3, 3'h0, 3'h3, 3'h7};
    for (int i = 0; i < 6; i++) begin
      cmd(op[i]);
      chk("mode", 24'({continuous_select, analog_on, clocks_run}), 24'(st[i]));
    end
    cmd(8'h98);
    cmd(8'h01);
    cmd(8'ha0);
    chk("invalid", 24'(invalid_seen), 24'h2);
    chk("halts", 24'(halt_seen), 24'h3);
    chk("ovf", 24'(rx_overflow), 24'h0);
  endtask
  task automatic t_write_read();
    wr(8'h40, 24'h123456);
    chk("cfg", configuration, 24'h123456);
    cmd(8'he0);
    rd(8'h00, 8'he8, rd_q);
    chk("read", rd_q, 24'h123456);
    chk("cont", 24'(continuous_select), 24'h1);
    wr(8'h40, 24'habcdef, 2);
    chk("partial", configuration, 24'h123456);
    rd(8'h0e, 8'hff, rd_q);
    chk("meas", rd_q, {19'h2c3a5, 5'h07});
    wr(8'h64, 24'h00000a);
    wr(8'h78, 24'h0000c3);
    wr(8'h74, 24'h800001);
    chk("omode", operation_mode, 24'h00000a);
    chk("ctrl", control, 24'h0000c3);
    chk("mask", interrupt_enable_mask, 24'h800001);
  endtask
  task automatic t_page();
    wr(8'h7e, 24'h000003);
    chk("page", 24'(page), 24'h3);
    rd(8'h0c, 8'hff, rd_q);
    chk("pg3", rd_q, 24'h0);
    wr(8'h7e, 24'h000000);
    status_set = 24'h000011;
    @(posedge core_clk);
    #3 status_set = 24'h0;
    wr(8'h5e, 24'h000001);
    chk("flags", event_flags, 24'h000010);
  endtask
  task automatic t_resync();
    logic [7:0] x;
    i_host.sel(1'h1);
    // Stray bit breaks byte alignment before the sync sequence
    i_host.bit_io(1'h1, x[0]);
    for (int i = 0; i < 4; i++) i_host.xfer(i < 3 ? 8'hff : 8'hfe, x);
    i_host.xfer(8'h40, x);
    for (int i = 0; i < 3; i++) i_host.xfer(8'h5a, x);
    i_host.sel(1'h0);
    chk("sync", configuration, 24'h5a5a5a);
    cmd(8'h80);
    chk("soft", configuration, CONFIGURATION_RESET);
    wr(8'h7e, 24'h000005);
    reset_pin_n = 1'h0;
    repeat (260) @(posedge core_clk);
    #3 reset_pin_n = 1'h1;
    repeat (20) @(posedge core_clk);
    chk("pin", 24'(page), 24'h0);
  endtask
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    if (invalid_cmd_pulse) invalid_seen++;
    if (halt_pulse) halt_seen++;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end
  initial begin
    rstn = 1'h0;
    reset_pin_n = 1'h1;
    status_set = 24'h0;
    repeat (5) @(posedge core_clk);
    #3 rstn = 1'h1;
    t_cmds();
    t_write_read();
    t_page();
    t_resync();
    end_sim();
  end
endmodule // scd_serial_command_decoder_test
`default_nettype wire
